// *** inc/rsrc_pkg.sv ***
/*
  Constants of the reset and stop-mode recovery controller: register
  byte addresses, field positions, reset values, sequence counts, states.
  Assumes a 12-bit register-file address decoded from the low bus address.
*/
`default_nettype none

package rsrc_pkg;

  // Register byte addresses
  localparam logic [11:0] ADDR_WDT_CTRL = 12'hFF0;
  localparam logic [11:0] ADDR_DBG_CTRL = 12'hF00;
  localparam logic [11:0] ADDR_OPTIONS  = 12'hF04;
  localparam int          ADDR_MSB      = 11;

  // Cause flags in the watchdog control register
  localparam int FLAG_POWERUP = 7;
  localparam int FLAG_STOP    = 6;
  localparam int FLAG_TIMEOUT = 5;
  localparam int FLAG_PIN     = 4;

  // Debugger control and option bits
  localparam int DBG_RESET_BIT     = 0;
  localparam int OPT_TIMEOUT_RESET = 0;
  localparam int OPT_BROWNOUT_STOP = 1;

  // Reset values
  localparam logic [7:0] WDT_CTRL_RESET = 8'h80;
  localparam logic [7:0] DBG_CTRL_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_RESET  = 8'h03;

  // Sequence counter widths in bits, and sequence lengths in cycles
  localparam int         WDO_WIDTH         = 7;
  localparam int         SYS_WIDTH         = 5;
  localparam int         PIN_WIDTH         = 3;
  localparam logic [6:0] WDO_CYCLES        = 7'h42;
  localparam logic [4:0] SYS_CYCLES        = 5'h10;
  localparam logic [2:0] PIN_FILTER_CYCLES = 3'h4;

  // First byte of the two-byte reset vector
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;

  // AHB-Lite
  localparam int         HTRANS_ACTIVE_BIT = 1;
  localparam logic [7:0] REG_PAD_ZERO      = 8'h00;
  localparam logic [23:0] RDATA_PAD_ZERO   = 24'h000000;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WDO = 2'b01,
    ST_SYS = 2'b11
  } rsrc_state_t;

endpackage

`default_nettype wire

// *** rtl/rsrc_counter.sv ***
/*
  Saturating up-counter with a terminal flag, used for the oscillator
  count, the system clock count and the reset pin filter.
  Assumes clear and advance are synchronous to mclk.
*/
`timescale 1ns/10ps
`default_nettype none

module rsrc_counter #(
  parameter int               WIDTH = 4,
  parameter logic [WIDTH-1:0] LIMIT = '1
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Control
  input  wire logic clear,
  input  wire logic advance,
  // Status
  output logic      done
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire              atLimit = (count_reg == LIMIT);

  // Saturation keeps done high until the next clear
  assign count_next = clear ? '0 :
                      (advance && !atLimit) ? count_reg + 1'b1 : count_reg;
  assign done       = atLimit;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule // rsrc_counter

`default_nettype wire

// *** rtl/rsrc_reset_ctrl.sv ***
/*
  Reset and stop-mode recovery controller with an AHB-Lite register slave.
  Assumes every source input is synchronous to mclk except the two pins,
  and wdoTick pulses once per watchdog oscillator cycle.
*/
// Notes on behaviour
// [R1] System reset from power-on, brown-out, timeout, reset pin or debugger request.
// [R2] In stop mode, timeout, enabled GPIO transition or debug pin low start recovery.
// [R3] Both kinds hold reset 66 oscillator cycles, then 16 system clocks.
// [R4] Stop recovery resets the processor, touches only the watchdog control register.
// [R5] System reset forces every GPIO pin to input from its start.
// [R6] System clock starts after the oscillator count; core idle for 16 more clocks.
// [R7] System reset reloads control registers that have defined reset values; the code leaves the options register at its value.
// [R8] On release the core fetches its vector from 0002H and 0003H.
// [R9] Power-on or brown-out outranks every other pending source.
// [R10] Debugger-requested reset leaves the debugger block untouched.
// [R11] Power-up counts 66 oscillator cycles, then 16 system clocks, before release.
// [R12] After power-on reset the power-up flag reads 1.
// [R13] Brown-out forces and holds reset; recovery runs the full power-on sequence.
// [R14] An option bit selects whether brown-out detection works in stop mode.
// [R15] Outside stop, timeout resets only when the select option is 1, the default.
// [R16] A timeout reset sets the timeout flag.
// [R17] Reset pin must stay low 4 system clocks before a reset starts.
// [R18] Pin low holds reset; a long hold releases right after the pin rises.
// [R19] A pin reset sets the pin reset flag.
// [R20] The debugger reset request bit clears itself during its reset.
// [R21] A debugger reset sets the power-up flag.
// [R22] Any stop recovery sets the stop flag; timeout recovery also the timeout flag.
// [R23] Both pins are synchronised before filtering; release is synchronous.
`timescale 1ns/10ps
`default_nettype none

module rsrc_reset_ctrl (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Reset and recovery sources
  input  wire logic        porActive,
  input  wire logic        brownoutDetector,
  input  wire logic        wdtTimeout,
  input  wire logic        resetPinN,
  input  wire logic        debugPinN,
  input  wire logic        gpioRecoveryEvent,
  input  wire logic        stopMode,
  input  wire logic        wdoTick,
  // Reset outputs
  output logic             cpuResetN,
  output logic             periphResetN,
  output logic             debuggerResetN,
  output logic             gpioForceInput,
  output logic             sysClkEnable,
  output logic             vectorFetch,
  output logic [15:0]      vectorAddr
);

  rsrc_pkg::rsrc_state_t state_reg, state_next;

  logic [7:0]  watchdogControl_reg, watchdogControl_next;
  logic [7:0]  debuggerControl_reg, debuggerControl_next;
  logic [7:0]  options_reg, options_next;
  logic        kindSys_reg, causeDbg_reg;
  logic        pinMeta_reg, pinLowSync_reg, dbgMeta_reg, dbgLowSync_reg;
  logic        cpuResetN_reg, periphResetN_reg, debuggerResetN_reg;
  logic        gpioForceInput_reg, sysClkEnable_reg, vectorFetch_reg;
  logic [15:0] vectorAddr_reg;
  logic [11:0] addrPh_reg;
  logic        wrPh_reg, rdPh_reg;
  logic        wdoDone, sysDone, pinFilt;

  // Bus decode
  wire busActive = hsel && htrans[rsrc_pkg::HTRANS_ACTIVE_BIT] && hready;
  wire wrWdt     = wrPh_reg && (addrPh_reg == rsrc_pkg::ADDR_WDT_CTRL);
  wire wrDbg     = wrPh_reg && (addrPh_reg == rsrc_pkg::ADDR_DBG_CTRL);
  wire wrOpt     = wrPh_reg && (addrPh_reg == rsrc_pkg::ADDR_OPTIONS);
  wire [7:0] wByte = hwdata[7:0];
  wire [7:0] rByte = (addrPh_reg == rsrc_pkg::ADDR_WDT_CTRL) ? watchdogControl_reg :
                     (addrPh_reg == rsrc_pkg::ADDR_DBG_CTRL) ? debuggerControl_reg :
                     (addrPh_reg == rsrc_pkg::ADDR_OPTIONS)  ? options_reg :
                     rsrc_pkg::REG_PAD_ZERO;

  // Source qualification
  wire stRun   = (state_reg == rsrc_pkg::ST_RUN);
  wire stWdo   = (state_reg == rsrc_pkg::ST_WDO);
  wire stSys   = (state_reg == rsrc_pkg::ST_SYS);
  wire inSysSeq = !stRun && kindSys_reg;
  wire optTimeoutReset = options_reg[rsrc_pkg::OPT_TIMEOUT_RESET];
  wire optBrownoutStop = options_reg[rsrc_pkg::OPT_BROWNOUT_STOP];
  wire dbgRequest = debuggerControl_reg[rsrc_pkg::DBG_RESET_BIT];
  // [R14] brown-out in stop
  wire brownoutLive = brownoutDetector && (!stopMode || optBrownoutStop);
  // [R13] hold while supply is low
  wire porHold = porActive || brownoutLive;
  // [R15] timeout reset select
  wire wdtSysReq = wdtTimeout && !stopMode && optTimeoutReset;
  // [R1] system reset sources
  wire otherReq = pinFilt || wdtSysReq || dbgRequest;
  // A pin still low after its own reset must not restart the count
  wire startSys = porHold || (!inSysSeq && otherReq);
  // [R2] stop-mode recovery sources
  wire stopReq = stopMode && (wdtTimeout || gpioRecoveryEvent || dbgLowSync_reg);
  wire startStop = stRun && stopReq && !startSys;
  // [R9] power-on outranks all
  wire causePor = porHold;
  wire causePin = !porHold && pinFilt;
  wire causeWdt = !porHold && !pinFilt && wdtSysReq;
  wire causeDbg = !porHold && !pinFilt && !wdtSysReq && dbgRequest;
  // [R18] release waits for the pin
  wire releaseOk = stSys && sysDone && !pinFilt && !startSys;

  // [R3] oscillator count then system clock count
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      rsrc_pkg::ST_RUN: begin
        if (startSys || startStop) begin
          state_next = rsrc_pkg::ST_WDO;
        end
      end
      rsrc_pkg::ST_WDO: begin
        if (!startSys && wdoDone) begin
          state_next = rsrc_pkg::ST_SYS;
        end
      end
      rsrc_pkg::ST_SYS: begin
        if (startSys) begin
          state_next = rsrc_pkg::ST_WDO;
        end else if (releaseOk) begin
          state_next = rsrc_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = rsrc_pkg::ST_WDO;
      end
    endcase
  end

  // [R11] oscillator count, restarted by a new system request
  rsrc_counter #(
    .WIDTH (rsrc_pkg::WDO_WIDTH),
    .LIMIT (rsrc_pkg::WDO_CYCLES)
  ) u_wdoCount (
    .mclk    (mclk),
    .resetn  (resetn),
    .clear   (!stWdo || startSys),
    .advance (wdoTick),
    .done    (wdoDone)
  );

  // [R6] system clock count with the core idle
  rsrc_counter #(
    .WIDTH (rsrc_pkg::SYS_WIDTH),
    .LIMIT (rsrc_pkg::SYS_CYCLES)
  ) u_sysCount (
    .mclk    (mclk),
    .resetn  (resetn),
    .clear   (!stSys),
    .advance (1'b1),
    .done    (sysDone)
  );

  // [R17] pin low for four clocks
  rsrc_counter #(
    .WIDTH (rsrc_pkg::PIN_WIDTH),
    .LIMIT (rsrc_pkg::PIN_FILTER_CYCLES)
  ) u_pinFilter (
    .mclk    (mclk),
    .resetn  (resetn),
    .clear   (!pinLowSync_reg),
    .advance (1'b1),
    .done    (pinFilt)
  );

  // [R12] cause flags; a new cause replaces the old, so the set wins over a clear
  always_comb begin
    watchdogControl_next = watchdogControl_reg;
    if (wrWdt) begin
      watchdogControl_next = watchdogControl_reg & ~wByte;
    end
    if (startSys) begin
      // [R7] defined reset value reloaded
      watchdogControl_next = rsrc_pkg::REG_PAD_ZERO;
      // [R21] debugger reset reads as power-up
      watchdogControl_next[rsrc_pkg::FLAG_POWERUP] = causePor || causeDbg;
      // [R19] pin cause flag
      watchdogControl_next[rsrc_pkg::FLAG_PIN] = causePin;
      // [R16] timeout cause flag
      watchdogControl_next[rsrc_pkg::FLAG_TIMEOUT] = causeWdt;
    end else if (startStop) begin
      // [R22] stop flag, plus timeout for a timeout recovery
      watchdogControl_next = rsrc_pkg::REG_PAD_ZERO;
      watchdogControl_next[rsrc_pkg::FLAG_STOP] = 1'b1;
      watchdogControl_next[rsrc_pkg::FLAG_TIMEOUT] = wdtTimeout;
    end
  end

  // [R20] request clears itself; a write in the same cycle still wins
  always_comb begin
    debuggerControl_next = debuggerControl_reg;
    if (startSys) begin
      debuggerControl_next[rsrc_pkg::DBG_RESET_BIT] = 1'b0;
    end
    if (wrDbg) begin
      debuggerControl_next[rsrc_pkg::DBG_RESET_BIT] = wByte[rsrc_pkg::DBG_RESET_BIT];
    end
  end

  // Option bits survive every generated reset, like fuses
  assign options_next = wrOpt ? (wByte & rsrc_pkg::OPTIONS_RESET) : options_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg           <= rsrc_pkg::ST_WDO;
      kindSys_reg         <= 1'b1;
      causeDbg_reg        <= 1'b0;
      watchdogControl_reg <= rsrc_pkg::WDT_CTRL_RESET;
      debuggerControl_reg <= rsrc_pkg::DBG_CTRL_RESET;
      options_reg         <= rsrc_pkg::OPTIONS_RESET;
    end else begin
      state_reg           <= state_next;
      watchdogControl_reg <= watchdogControl_next;
      debuggerControl_reg <= debuggerControl_next;
      options_reg         <= options_next;
      if (startSys || startStop) begin
        kindSys_reg  <= startSys;
        causeDbg_reg <= causeDbg;
      end
    end
  end

  // [R23] two-flop synchronisers for both pins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_reg    <= 1'b0;
      pinLowSync_reg <= 1'b0;
      dbgMeta_reg    <= 1'b0;
      dbgLowSync_reg <= 1'b0;
    end else begin
      pinMeta_reg    <= !resetPinN;
      pinLowSync_reg <= pinMeta_reg;
      dbgMeta_reg    <= !debugPinN;
      dbgLowSync_reg <= dbgMeta_reg;
    end
  end

  wire busyNext   = (state_next != rsrc_pkg::ST_RUN);
  wire kindSysNext = (startSys || startStop) ? startSys : kindSys_reg;
  wire dbgKindNext = (startSys || startStop) ? causeDbg : causeDbg_reg;

  // [R23] release is a registered, synchronous edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cpuResetN_reg      <= 1'b0;
      periphResetN_reg   <= 1'b0;
      debuggerResetN_reg <= 1'b0;
      gpioForceInput_reg <= 1'b1;
      sysClkEnable_reg   <= 1'b0;
      vectorFetch_reg    <= 1'b0;
      vectorAddr_reg     <= rsrc_pkg::RESET_VECTOR_ADDR;
    end else begin
      cpuResetN_reg      <= !busyNext;
      // [R4] stop recovery spares peripherals
      periphResetN_reg   <= !(busyNext && kindSysNext);
      // [R10] debugger spared on its own reset
      debuggerResetN_reg <= !(busyNext && kindSysNext && !dbgKindNext);
      // [R5] GPIO forced to input
      gpioForceInput_reg <= busyNext && kindSysNext;
      // [R6] clock stopped during oscillator count
      sysClkEnable_reg   <= (state_next != rsrc_pkg::ST_WDO);
      // [R8] vector fetch at release
      vectorFetch_reg    <= releaseOk;
      vectorAddr_reg     <= rsrc_pkg::RESET_VECTOR_ADDR;
    end
  end

  // Zero-wait slave: address captured, data applied in the next cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addrPh_reg <= '0;
      wrPh_reg   <= 1'b0;
      rdPh_reg   <= 1'b0;
    end else if (hready) begin
      addrPh_reg <= haddr[rsrc_pkg::ADDR_MSB:0];
      wrPh_reg   <= busActive && hwrite;
      rdPh_reg   <= busActive && !hwrite;
    end
  end

  // Unmapped addresses read zero and ignore writes; always OKAY
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = rdPh_reg ? {rsrc_pkg::RDATA_PAD_ZERO, rByte} : '0;
  assign cpuResetN      = cpuResetN_reg;
  assign periphResetN   = periphResetN_reg;
  assign debuggerResetN = debuggerResetN_reg;
  assign gpioForceInput = gpioForceInput_reg;
  assign sysClkEnable   = sysClkEnable_reg;
  assign vectorFetch    = vectorFetch_reg;
  assign vectorAddr     = vectorAddr_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_enterSys;
    stWdo ##1 stSys;
  endsequence

  property p_wdoFirst;
    s_enterSys |-> $past(wdoDone);
  endproperty
  a_wdoFirst: assert property (p_wdoFirst) else $error("system count began early"); // [R3]

  property p_sysLen;
    $rose(cpuResetN) |-> $past(sysDone) && $past(stSys);
  endproperty
  a_sysLen: assert property (p_sysLen) else $error("released before system count"); // [R11]

  property p_clkStop;
    stWdo ##1 stWdo |-> !sysClkEnable;
  endproperty
  a_clkStop: assert property (p_clkStop) else $error("clock ran in oscillator count"); // [R6]

  property p_gpioIn;
    startSys |=> gpioForceInput && !periphResetN && !cpuResetN;
  endproperty
  a_gpioIn: assert property (p_gpioIn) else $error("gpio not forced on reset"); // [R5]

  property p_stopKeep;
    startStop |=> periphResetN && !cpuResetN && watchdogControl_reg[rsrc_pkg::FLAG_STOP];
  endproperty
  a_stopKeep: assert property (p_stopKeep) else $error("stop recovery wrong"); // [R22]

  property p_dbgSpared;
    startSys && causeDbg |=> debuggerResetN && !cpuResetN && !dbgRequest
      && watchdogControl_reg[rsrc_pkg::FLAG_POWERUP];
  endproperty
  a_dbgSpared: assert property (p_dbgSpared) else $error("debugger reset wrong"); // [R10]

  property p_porWins;
    startSys && porHold |=> watchdogControl_reg[rsrc_pkg::FLAG_POWERUP]
      && !watchdogControl_reg[rsrc_pkg::FLAG_PIN] && stWdo;
  endproperty
  a_porWins: assert property (p_porWins) else $error("power-on lost priority"); // [R9]

  property p_pinFilter;
    $rose(pinFilt) |-> $past(pinLowSync_reg, 1) && $past(pinLowSync_reg, 2)
      && $past(pinLowSync_reg, 3) && $past(pinLowSync_reg, 4);
  endproperty
  a_pinFilter: assert property (p_pinFilter) else $error("pin filter too short"); // [R17]

  property p_pinHold;
    stSys && sysDone && pinFilt |=> !cpuResetN;
  endproperty
  a_pinHold: assert property (p_pinHold) else $error("released with pin low"); // [R18]

  property p_wdtSel;
    wdtTimeout && !stopMode && !optTimeoutReset && stRun && !porHold && !pinFilt && !dbgRequest
      |=> cpuResetN;
  endproperty
  a_wdtSel: assert property (p_wdtSel) else $error("timeout reset ignored option"); // [R15]

  property p_vector;
    $rose(cpuResetN) |-> vectorFetch && vectorAddr == rsrc_pkg::RESET_VECTOR_ADDR;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector fetch at release"); // [R8]

endmodule // rsrc_reset_ctrl

`default_nettype wire

// *** tb/reset_and_stop_recovery_controller_tb.sv ***
/*
  Self-checking bench for the reset controller: AHB-Lite register access
  and reset sources. Assumes rsrc_pkg and the source model are compiled.
*/
`timescale 1ns/10ps
`default_nettype none

module reset_and_stop_recovery_controller_tb;
  logic        mclk;
  logic        resetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic        porActive;
  logic        brownoutDetector;
  logic        wdtTimeout;
  logic        debugPinN;
  logic        gpioRecoveryEvent;
  logic        stopMode;
  logic        wdoTick;
  logic        resetPinN;
  logic        pinStart;
  logic [15:0] pinLen;
  logic        cpuResetN;
  logic        periphResetN;
  logic        debuggerResetN;
  logic        gpioForceInput;
  logic        sysClkEnable;
  logic        vectorFetch;
  logic [15:0] vectorAddr;
  logic [31:0] rd;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;

  assign hready = hreadyout;

  rsrc_reset_ctrl dut_u (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .porActive(porActive), .brownoutDetector(brownoutDetector), .wdtTimeout(wdtTimeout),
    .resetPinN(resetPinN), .debugPinN(debugPinN), .gpioRecoveryEvent(gpioRecoveryEvent),
    .stopMode(stopMode), .wdoTick(wdoTick), .cpuResetN(cpuResetN), .periphResetN(periphResetN),
    .debuggerResetN(debuggerResetN), .gpioForceInput(gpioForceInput), .sysClkEnable(sysClkEnable),
    .vectorFetch(vectorFetch), .vectorAddr(vectorAddr));

  rsrc_source_model src_u (.mclk(mclk), .pinStart(pinStart), .pinLen(pinLen), .wdoTick(wdoTick),
    .resetPinN(resetPinN));

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic readChk(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rd, {24'h000000, e});
    chk({31'h00000000, hresp}, 32'h0);
  endtask

  task automatic pulse(input int k, input int len);
    @(posedge mclk);
    if (k == 0) wdtTimeout <= 1'b1;
    if (k == 1) gpioRecoveryEvent <= 1'b1;
    if (k == 2) debugPinN <= 1'b0;
    if (k == 3) brownoutDetector <= 1'b1;
    if (k == 4) porActive <= 1'b1;
    // At least one edge, so a zero length still gives a one-cycle pulse
    repeat (len + 1) @(posedge mclk);
    wdtTimeout <= 1'b0;
    gpioRecoveryEvent <= 1'b0;
    debugPinN <= 1'b1;
    brownoutDetector <= 1'b0;
    porActive <= 1'b0;
  endtask

  task automatic pinReq(input logic [15:0] len);
    @(posedge mclk);
    pinStart <= 1'b1;
    pinLen   <= len;
    @(posedge mclk);
    pinStart <= 1'b0;
  endtask

  task automatic quiet(input int n);
    logic low;
    low = 1'b0;
    repeat (n) begin
      @(negedge mclk);
      low |= !cpuResetN;
    end
    chk(32'(low), 32'h0);
  endtask

  // Follows one reset sequence; sys selects system reset versus stop recovery
  task automatic runSeq(input logic sys, input logic dbgKept, input logic countIt);
    int   ticks;
    int   sysc;
    int   n;
    logic pLow;
    logic dLow;
    logic gHigh;
    ticks = 0;
    sysc = 0;
    n = 0;
    pLow = 1'b0;
    dLow = 1'b0;
    gHigh = 1'b0;
    // Sample only at falling edges, never in the launching time step
    @(negedge mclk);
    while (cpuResetN !== 1'b0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(cpuResetN), 32'h0);
    while (cpuResetN === 1'b0) begin
      if (!sysClkEnable && wdoTick) ticks++;
      if (sysClkEnable) sysc++;
      pLow |= !periphResetN;
      dLow |= !debuggerResetN;
      gHigh |= gpioForceInput;
      @(negedge mclk);
    end
    chk(32'(vectorFetch), 32'h1);
    chk({16'h0000, vectorAddr}, {16'h0000, rsrc_pkg::RESET_VECTOR_ADDR});
    if (countIt) begin
      chk(32'(ticks), 32'(rsrc_pkg::WDO_CYCLES));
      // System state lasts the count plus the registered release edge
      chk(32'(sysc), 32'(rsrc_pkg::SYS_CYCLES) + 32'h1);
    end
    chk(32'(pLow), 32'(sys));
    chk(32'(gHigh), 32'(sys));
    chk(32'(dLow), 32'(sys & !dbgKept));
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Run needs about 3100 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    int n;
    resetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    porActive = 1'b0;
    brownoutDetector = 1'b0;
    wdtTimeout = 1'b0;
    debugPinN = 1'b1;
    gpioRecoveryEvent = 1'b0;
    stopMode = 1'b0;
    pinStart = 1'b0;
    pinLen = 16'h0000;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    runSeq(1'b1, 1'b0, 1'b1);
    readChk(12'hFF0, 8'h80);
    readChk(12'hF04, 8'h03);
    readChk(12'hFF4, 8'h00);
    $display("test power_on done");
    xfer(1'b1, 12'hF00, 8'h01);
    runSeq(1'b1, 1'b1, 1'b1);
    readChk(12'hF00, 8'h00);
    readChk(12'hFF0, 8'h80);
    xfer(1'b1, 12'hFF0, 8'h80);
    readChk(12'hFF0, 8'h00);
    $display("test debugger done");
    pulse(0, 0);
    runSeq(1'b1, 1'b0, 1'b1);
    readChk(12'hFF0, 8'h20);
    xfer(1'b1, 12'hF04, 8'h02);
    pulse(0, 0);
    quiet(40);
    $display("test timeout done");
    pinReq(16'h0003);
    quiet(30);
    pinReq(16'h0258);
    repeat (500) @(negedge mclk);
    chk(32'(cpuResetN), 32'h0);
    while (resetPinN === 1'b0) @(negedge mclk);
    n = 0;
    while (cpuResetN === 1'b0 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(n <= 6), 32'h1);
    readChk(12'hFF0, 8'h10);
    $display("test pin done");
    stopMode <= 1'b1;
    pulse(1, 0);
    runSeq(1'b0, 1'b0, 1'b1);
    readChk(12'hFF0, 8'h40);
    readChk(12'hF04, 8'h02);
    pulse(0, 0);
    runSeq(1'b0, 1'b0, 1'b1);
    readChk(12'hFF0, 8'h60);
    pulse(2, 1);
    runSeq(1'b0, 1'b0, 1'b1);
    readChk(12'hFF0, 8'h40);
    $display("test stop_recovery done");
    xfer(1'b1, 12'hF04, 8'h01);
    pulse(3, 5);
    quiet(40);
    xfer(1'b1, 12'hF04, 8'h03);
    pulse(3, 5);
    runSeq(1'b1, 1'b0, 1'b0);
    readChk(12'hFF0, 8'h80);
    stopMode <= 1'b0;
    pinReq(16'h0008);
    pulse(4, 8);
    runSeq(1'b1, 1'b0, 1'b0);
    readChk(12'hFF0, 8'h80);
    $display("test brownout done");
    summarize();
  end
endmodule // reset_and_stop_recovery_controller_tb

`default_nettype wire

// *** tb/rsrc_source_model.sv ***
/*
  Far-side model: watchdog oscillator tick and external reset pin.
  Assumes the bench commands pin holds of a chosen length.
*/
`timescale 1ns/10ps
`default_nettype none

module rsrc_source_model #(
  parameter int TICK_DIV = 4
) (
  // Clock
  input  wire logic        mclk,
  // Commands
  input  wire logic        pinStart,
  input  wire logic [15:0] pinLen,
  // Sources
  output logic             wdoTick,
  output logic             resetPinN
);
  logic [7:0]  divCnt = 8'h00;
  logic [15:0] pinCnt = 16'h0000;

  // Oscillator keeps running through reset, slower than mclk
  always @(posedge mclk) begin
    divCnt  <= (divCnt >= 8'(TICK_DIV - 1)) ? 8'h00 : divCnt + 8'h01;
    wdoTick <= (divCnt == 8'h00);
  end

  // pin held low for the commanded span
  always @(posedge mclk) begin
    if (pinStart) begin
      pinCnt <= pinLen;
    end else if (pinCnt != 16'h0000) begin
      pinCnt <= pinCnt - 16'h0001;
    end
  end

  // Internal pull-up: released pin reads high
  assign resetPinN = (pinCnt == 16'h0000);
endmodule // rsrc_source_model

`default_nettype wire
